// file: rtl/spi_link_pkg.sv
// constants and types shared by the spi slave link and its shifter
package spi_link_pkg;
  localparam int          WORD_W        = 16;
  localparam logic [9:0]  SETUP_ADDR    = 10'h1C8;
  localparam logic [7:0]  SETUP_RESET   = 8'h0A;
  localparam int          SLEW_BIT      = 7;
  localparam int          MODE_BIT      = 6;
  localparam int          IRQ_EN_BIT    = 5;
  localparam int          WD_MSB        = 4;
  localparam int          RW_BIT        = 15;
  localparam int          ADDR_MSB      = 14;
  localparam int          ADDR_LSB      = 5;
  localparam int          CNT_MSB       = 4;
  localparam logic [12:0] CHECK_PATTERN = 13'h1555;
  localparam int          WD_SHIFT      = 15;  // times 32768
  localparam logic [3:0]  BIT_LAST      = 4'hF;
  localparam logic [4:0]  CNT_ZERO      = 5'h00;
  typedef enum logic [1:0] {
    ST_CTRL  = 2'b00,
    ST_DATA  = 2'b01,
    ST_ERROR = 2'b10
  } proto_state_t;
endpackage : spi_link_pkg

// file: rtl/spi_word_shifter.sv
// serial shifter: sixteen bit words over sampled spi pins
`timescale 1ns/1ns
`default_nettype none
module spi_word_shifter (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // synchronised pins
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic        i_mosi,
  // word load for output
  input  wire logic [15:0] i_tx_word,
  // results
  output logic             o_miso,
  output logic             o_word_valid,
  output logic [15:0]      o_rx_word,
  output logic             o_fall
);
  typedef struct packed {
    logic        sck_d;
    logic [3:0]  bit_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic        miso;
    logic        valid;
    logic [15:0] word;
    logic        fall;
  } shift_t;
  shift_t st_reg;
  shift_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // edge detect and shift; the word loads when the count wraps
  always_comb
  begin
    st_next       = st_reg;
    st_next.valid = 1'b0;
    st_next.fall  = 1'b0;
    st_next.sck_d = i_sck;
    if (i_cs_n)
    begin
      // idle: realign and preload the next answer
      st_next.bit_cnt = '0;
      st_next.tx      = i_tx_word;
      st_next.miso    = i_tx_word[15];
    end
    else if (i_sck && !st_reg.sck_d)
    begin
      // rising edge drives the next bit, msb first; the first rising
      // edge of a word loads the answer, so read data fetched at the
      // previous word boundary still reaches this slot in time
      if (st_reg.bit_cnt == 4'h0)
      begin
        st_next.miso = i_tx_word[15];
        st_next.tx   = i_tx_word;
      end
      else
        st_next.miso = st_reg.tx[15];
    end
    else if (!i_sck && st_reg.sck_d)
    begin
      // falling edge samples mosi
      st_next.fall    = 1'b1;
      st_next.rx      = {st_reg.rx[14:0], i_mosi};
      st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
      st_next.tx      = {st_reg.tx[14:0], 1'b0};
      if (st_reg.bit_cnt == spi_link_pkg::BIT_LAST)
      begin
        st_next.valid = 1'b1;
        st_next.word  = {st_reg.rx[14:0], i_mosi};
      end
    end
  end

  // register the state; clock enable freezes it
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      st_reg <= '0;
    else if (i_ce)
      st_reg <= st_next;
  end

  assign o_miso       = st_reg.miso;
  assign o_word_valid = st_reg.valid;
  assign o_rx_word    = st_reg.word;
  assign o_fall       = st_reg.fall;
endmodule : spi_word_shifter
`default_nettype wire

// file: rtl/spi_link_slave.sv
// spi slave top: pin sync, burst protocol, setup register, watchdog
`timescale 1ns/1ns
`default_nettype none
module spi_link_slave (
  // clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // spi pins
  input  wire logic        i_cs_n,
  input  wire logic        i_sck,
  input  wire logic        i_mosi,
  output logic             o_miso,
  output logic             o_miso_oe_n,
  // system clock presence flag
  input  wire logic        i_cksys_missing,
  // register target port
  output logic             o_reg_wr,
  output logic             o_reg_rd,
  output logic [9:0]       o_reg_addr,
  output logic [15:0]      o_reg_wdata,
  input  wire logic [15:0] i_reg_rdata,
  // setup outputs
  output logic             o_miso_slew,
  output logic             o_mode_b,
  output logic             o_irq
);
  typedef struct packed {
    logic [1:0]  cs_s;
    logic [1:0]  sck_s;
    logic [1:0]  mosi_s;
    logic [1:0]  ckm_s;
    spi_link_pkg::proto_state_t state;
    logic        rd;
    logic [9:0]  addr;
    logic [4:0]  left;
    logic [7:0]  setup;
    logic [20:0] wd_cnt;
    logic        frame_err;
    logic        word_err;
    logic        part;         // word in progress on the link
    logic        wr;
    logic        rstb;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        irq;
    logic        oe_n;
  } top_t;
  top_t st_reg;
  top_t st_next;

  logic        word_valid;
  logic [15:0] rx_word;
  logic        sh_miso;
  logic        sh_fall;
  logic [15:0] tx_word;
  logic [20:0] wd_limit;

  ////////////////////////////////////////////////////////////////////////////
  // shifter runs on the second sync stage only
  spi_word_shifter u_shift (
    .i_clk        (i_clk),
    .i_rst_n      (i_rst_n),
    .i_ce         (i_ce),
    .i_cs_n       (st_reg.cs_s[1]),
    .i_sck        (st_reg.sck_s[1]),
    .i_mosi       (st_reg.mosi_s[1]),
    .i_tx_word    (tx_word),
    .o_miso       (sh_miso),
    .o_word_valid (word_valid),
    .o_rx_word    (rx_word),
    .o_fall       (sh_fall)
  );

  // watchdog limit (wd+1)*32768 system clock cycles
  assign wd_limit = 21'({16'h0000, st_reg.setup[spi_link_pkg::WD_MSB:0]}
                    + 21'h1) << spi_link_pkg::WD_SHIFT;

  ////////////////////////////////////////////////////////////////////////////
  // answer word: check pattern and status on command, data on read
  always_comb
  begin
    if (st_reg.state == spi_link_pkg::ST_DATA && st_reg.rd)
      tx_word = st_reg.rdata;
    else
      tx_word = {spi_link_pkg::CHECK_PATTERN, st_reg.ckm_s[1],
                 st_reg.frame_err, st_reg.word_err};
  end

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine and setup register
  always_comb
  begin
    st_next        = st_reg;
    st_next.cs_s   = {st_reg.cs_s[0], i_cs_n};
    st_next.sck_s  = {st_reg.sck_s[0], i_sck};
    st_next.mosi_s = {st_reg.mosi_s[0], i_mosi};
    st_next.ckm_s  = {st_reg.ckm_s[0], i_cksys_missing};
    st_next.wr     = 1'b0;
    st_next.rstb   = 1'b0;
    // only drive miso while selected
    st_next.oe_n   = st_reg.cs_s[1];
    // track a word in progress: a falling edge that closes no word
    if (word_valid)
      st_next.part = 1'b0;
    else if (sh_fall)
      st_next.part = 1'b1;
    // deselect realigns the shifter, so the partial word is dropped
    if (st_reg.cs_s[1])
      st_next.part = 1'b0;
    // read data is taken in the same cycle as the strobe; the setup register
    // lives here, so its address is answered internally
    if (st_reg.rstb && o_reg_addr == spi_link_pkg::SETUP_ADDR)
      st_next.rdata = {8'h00, st_reg.setup};
    else if (st_reg.rstb)
      st_next.rdata = i_reg_rdata;
    unique case (st_reg.state)
      spi_link_pkg::ST_CTRL:
      begin
        st_next.wd_cnt = '0;
        if (word_valid)
        begin
          // control word decode
          st_next.rd   = rx_word[spi_link_pkg::RW_BIT];
          st_next.addr = rx_word[spi_link_pkg::ADDR_MSB:
                                 spi_link_pkg::ADDR_LSB];
          st_next.left = rx_word[spi_link_pkg::CNT_MSB:0];
          st_next.frame_err = 1'b0;
          st_next.word_err  = 1'b0;
          if (rx_word[spi_link_pkg::CNT_MSB:0] != spi_link_pkg::CNT_ZERO)
          begin
            st_next.state = spi_link_pkg::ST_DATA;
            if (rx_word[spi_link_pkg::RW_BIT])
            begin
              st_next.rstb = 1'b1;
              // prefetch first read word
            end
          end
        end
      end
      spi_link_pkg::ST_DATA:
      begin
        // mode A gap watchdog; mode B frames end at chip select
        if (!st_reg.setup[spi_link_pkg::MODE_BIT] && st_reg.cs_s[1])
          st_next.wd_cnt = st_reg.wd_cnt + 21'h1;
        else
          st_next.wd_cnt = '0;
        if (st_reg.setup[spi_link_pkg::MODE_BIT] && st_reg.cs_s[1])
        begin
          st_next.frame_err = 1'b1;
          st_next.state     = spi_link_pkg::ST_ERROR;
        end
        else if (st_reg.wd_cnt >= wd_limit)
        begin
          st_next.frame_err = 1'b1;
          st_next.state     = spi_link_pkg::ST_ERROR;
        end
        else if (word_valid)
        begin
          st_next.addr = st_reg.addr + 10'h001;
          st_next.left = st_reg.left - 5'h01;
          if (!st_reg.rd)
          begin
            st_next.wr    = 1'b1;
            st_next.wdata = rx_word;
            // setup register write, mode takes effect on the next cycle, even inside this burst
            if (st_reg.addr == spi_link_pkg::SETUP_ADDR)
              st_next.setup = rx_word[7:0];
          end
          else if (st_reg.left != 5'h01)
            st_next.rstb = 1'b1;
          if (st_reg.left == 5'h01)
            st_next.state = spi_link_pkg::ST_CTRL;
        end
      end
      spi_link_pkg::ST_ERROR:
      begin
        // stay until the host releases chip select
        if (st_reg.cs_s[1])
          st_next.state = spi_link_pkg::ST_CTRL;
      end
      default:
        st_next.state = spi_link_pkg::ST_CTRL;
    endcase
    // a partial word at chip select rise is a word error; placed after
    // the decode so that the set wins over a clear in the same cycle
    if (st_reg.cs_s[1] == 1'b0 && st_reg.cs_s[0] == 1'b1 && st_reg.part)
      st_next.word_err = 1'b1;
    st_next.irq = st_reg.setup[spi_link_pkg::IRQ_EN_BIT] &
                  (st_next.frame_err | st_next.word_err);
  end

  // register the state; reset deselects the sync stages and loads the setup default
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_reg       <= '0;
      st_reg.cs_s  <= 2'h3;
      st_reg.oe_n  <= 1'b1;
      st_reg.setup <= spi_link_pkg::SETUP_RESET;
    end
    else if (i_ce)
      st_reg <= st_next;
  end

  // outputs
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_reg_addr  <= '0;
      o_reg_wdata <= '0;
      o_reg_wr    <= 1'b0;
      o_reg_rd    <= 1'b0;
      o_miso      <= 1'b0;
    end
    else if (i_ce)
    begin
      o_reg_wr    <= st_next.wr;
      o_reg_rd    <= st_next.rstb;
      o_reg_wdata <= st_next.wdata;
      o_reg_addr  <= st_next.wr ? st_reg.addr : st_next.addr;
      o_miso      <= sh_miso;
    end
  end

  assign o_miso_oe_n = st_reg.oe_n;
  assign o_miso_slew = st_reg.setup[spi_link_pkg::SLEW_BIT];
  assign o_mode_b    = st_reg.setup[spi_link_pkg::MODE_BIT];
  assign o_irq       = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_RESET_SETUP: assert property (@(posedge i_clk)
    $rose(i_rst_n) |-> st_reg.setup == spi_link_pkg::SETUP_RESET)
    else $error("setup reset value wrong");
  AST_IRQ_GATED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 o_irq |-> $past(st_reg.setup[spi_link_pkg::IRQ_EN_BIT]))
    else $error("irq without enable");
  AST_CTRL_DECODE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_reg.state == spi_link_pkg::ST_CTRL && word_valid
     && rx_word[4:0] != 5'h00) |=> st_reg.state == spi_link_pkg::ST_DATA
     && st_reg.left == $past(rx_word[4:0]))
    else $error("control word not decoded");
  AST_ADDR_INC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_next.state == spi_link_pkg::ST_DATA
     && st_reg.state == spi_link_pkg::ST_DATA && word_valid)
    |=> st_reg.addr == $past(st_reg.addr) + 10'h001)
    else $error("address not incremented");
  AST_DONE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_reg.state == spi_link_pkg::ST_DATA && word_valid
     && st_reg.left == 5'h01 && st_next.state != spi_link_pkg::ST_ERROR)
    |=> st_reg.state == spi_link_pkg::ST_CTRL)
    else $error("burst did not complete");
  AST_WATCHDOG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_reg.state == spi_link_pkg::ST_DATA
     && st_reg.wd_cnt >= wd_limit)
    |=> st_reg.frame_err && st_reg.state == spi_link_pkg::ST_ERROR)
    else $error("watchdog expiry missed");
  AST_CMD_ANSWER: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_reg.state == spi_link_pkg::ST_CTRL
    |-> tx_word[15:3] == spi_link_pkg::CHECK_PATTERN)
    else $error("check pattern wrong");
  AST_WRITE_STROBE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_reg_wr |-> $past(st_reg.rd) == 1'b0 ##1 !o_reg_wr)
    else $error("write strobe in read burst");

  ////////////////////////////////////////////////////////////////////////////
  // protocol checks on errors, strobes and the enable

  // deselect in the middle of a word flags a word error
  AST_WORD_ERR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && !st_reg.cs_s[1] && st_reg.cs_s[0] && st_reg.part)
    |=> st_reg.word_err)
    else $error("partial word not flagged");

  // mode B burst cut by chip select is a frame error
  AST_MODE_B_FRAME: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_reg.state == spi_link_pkg::ST_DATA
     && st_reg.setup[spi_link_pkg::MODE_BIT] && st_reg.cs_s[1])
    |=> st_reg.frame_err && st_reg.state == spi_link_pkg::ST_ERROR)
    else $error("mode B cut frame missed");

  // error state is left once the host releases chip select
  AST_ERROR_EXIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_reg.state == spi_link_pkg::ST_ERROR && st_reg.cs_s[1])
    |=> st_reg.state == spi_link_pkg::ST_CTRL)
    else $error("error state not left");

  // a zero count control word leaves the engine waiting for control
  AST_COUNT_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_reg.state == spi_link_pkg::ST_CTRL && word_valid
     && rx_word[4:0] == 5'h00)
    |=> st_reg.state == spi_link_pkg::ST_CTRL)
    else $error("zero count left control");

  // a read control word fetches its start address at once
  AST_READ_PREFETCH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_reg.state == spi_link_pkg::ST_CTRL && word_valid
     && rx_word[15] && rx_word[4:0] != 5'h00)
    |=> o_reg_rd && o_reg_addr == $past(rx_word[14:5]))
    else $error("read prefetch address wrong");

  // every write data word lands at the current burst address
  AST_WR_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_reg.state == spi_link_pkg::ST_DATA && !st_reg.rd
     && word_valid && st_next.state != spi_link_pkg::ST_ERROR)
    |=> o_reg_wr && o_reg_addr == $past(st_reg.addr)
     && o_reg_wdata == $past(rx_word))
    else $error("write strobe address or data wrong");

  // a data word at the setup address loads the setup register
  AST_SETUP_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_reg.state == spi_link_pkg::ST_DATA && !st_reg.rd
     && word_valid && st_next.state != spi_link_pkg::ST_ERROR
     && st_reg.addr == spi_link_pkg::SETUP_ADDR)
    |=> st_reg.setup == $past(rx_word[7:0]))
    else $error("setup register not written");

  // mode A gap counter runs while chip select is high inside a burst
  AST_WD_COUNT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_reg.state == spi_link_pkg::ST_DATA
     && !st_reg.setup[spi_link_pkg::MODE_BIT] && st_reg.cs_s[1]
     && st_next.state == spi_link_pkg::ST_DATA)
    |=> st_reg.wd_cnt == $past(st_reg.wd_cnt) + 21'h1)
    else $error("gap counter stalled");

  // an enabled error raises the request on the next cycle
  AST_IRQ_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && st_reg.setup[spi_link_pkg::IRQ_EN_BIT]
     && (st_next.frame_err || st_next.word_err))
    |=> o_irq)
    else $error("irq not raised");

  // read strobes are single cycle pulses
  AST_READ_PULSE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && o_reg_rd) |=> !o_reg_rd)
    else $error("read strobe too long");

  // clock enable low freezes the whole engine
  AST_CE_FREEZE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_ce |=> $stable(st_reg))
    else $error("state moved with enable low");
endmodule : spi_link_slave
`default_nettype wire

// file: test/spi_host_model.sv
// host model: spi master, phase one, polarity zero
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  // spi pins
  output logic      o_cs_n,
  output logic      o_sck,
  input  wire logic i_miso,
  output logic      o_mosi
);
  // idle: deselected, clock low between frames
  initial
  begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_mosi = 1'b0;
  end
  // slow edges on cs so the two-stage sync settles
  task automatic select(input logic on);
    #203;
    o_cs_n = !on;
    #203;
  endtask : select
  // shift nbits msb first: drive on rising, sample on falling
  task automatic word(input logic [15:0] tx, input int nbits,
                      output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 15; i > 15 - nbits; i--)
    begin
      o_sck  = 1'b1;
      o_mosi = tx[i];
      #80;
      o_sck = 1'b0;
      rx[i] = i_miso;
      #80;
    end
    // released data line must not show a stale value
    o_mosi = ~o_mosi;
  endtask : word
endmodule : spi_host_model
`default_nettype wire

// file: test/tb_top.sv
// bench for the spi slave link with its setup register
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk;
  logic        rst_n;
  logic        ce;
  logic        cks_miss;
  wire         cs_n;
  wire         sck;
  wire         mosi;
  logic        miso;
  logic        oe_n;
  logic        reg_wr;
  logic        reg_rd;
  logic [9:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        slew;
  logic        mode_b;
  logic        irq;
  logic [9:0]  wr_addr;  // last write strobe address
  logic [15:0] wr_data;  // last write strobe data
  logic [15:0] rx;
  int          fails;
  int          n_checks;
  ////////////////////////////////////////////////////////////////
  // register target answers a pattern built from the address
  assign reg_rdata = {6'h15, reg_addr};
  spi_link_slave DUT (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_cs_n(cs_n), .i_sck(sck), .i_mosi(mosi), .o_miso(miso),
    .o_miso_oe_n(oe_n), .i_cksys_missing(cks_miss), .o_reg_wr(reg_wr),
    .o_reg_rd(reg_rd), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
    .i_reg_rdata(reg_rdata), .o_miso_slew(slew), .o_mode_b(mode_b),
    .o_irq(irq));
  spi_host_model host (.o_cs_n(cs_n), .o_sck(sck), .i_miso(miso),
    .o_mosi(mosi));
  // capture write strobes, which stand a single cycle
  always @(posedge clk)
  begin
    if (reg_wr)
    begin
      wr_addr <= reg_addr;
      wr_data <= reg_wdata;
    end
  end
  // 50 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one full word exchange
  task automatic xfer(input logic [15:0] tx);
    host.word(tx, 16, rx);
  endtask : xfer
  // one-word write frame with cs held throughout
  task automatic wr1(input logic [9:0] a, input logic [15:0] d,
                     input logic [15:0] ans);
    host.select(1'b1);
    xfer({1'b0, a, 5'h01});
    check(rx, ans);
    xfer(d);
    host.select(1'b0);
  endtask : wr1
  task automatic t_reset;
    check({13'h0000, oe_n, mode_b, irq}, 16'h0004);
    host.select(1'b1);
    check({15'h0000, oe_n}, 16'h0000);
    xfer(16'hB901);
    check(rx, 16'hAAA8);
    xfer(16'h0000);
    check(rx, 16'h000A);
    host.select(1'b0);
  endtask : t_reset
  task automatic t_mode_b;
    wr1(10'h1C8, 16'h00E0, 16'hAAA8);
    check({wr_addr, wr_data[7:2]}, {10'h1C8, 6'h38});
    check({14'h0000, slew, mode_b}, 16'h0003);
  endtask : t_mode_b
  // cs released inside a mode B burst
  task automatic t_frame_err;
    host.select(1'b1);
    xfer(16'h3902);
    xfer(16'h00E0);
    host.select(1'b0);
    check({15'h0000, irq}, 16'h0001);
    wr1(10'h1C8, 16'h002A, 16'hAAAA);
    check({14'h0000, irq, mode_b}, 16'h0000);
  endtask : t_frame_err
  // cs released after half a word
  task automatic t_word_err;
    host.select(1'b1);
    host.word(16'hFFFF, 8, rx);
    host.select(1'b0);
    check({15'h0000, irq}, 16'h0001);
  endtask : t_word_err
  // three-word read burst with the system clock flagged missing
  task automatic t_burst;
    @(negedge clk);
    cks_miss = 1'b1;
    host.select(1'b1);
    xfer(16'h8203);
    check(rx, 16'hAAAD);
    for (int i = 0; i < 3; i++)
    begin
      xfer(16'h0000);
      check(rx, {6'h15, 10'h010 + 10'(i)});
    end
    host.select(1'b0);
    check({15'h0000, irq}, 16'h0000);
    @(negedge clk);
    cks_miss = 1'b0;
  endtask : t_burst
  // enable low: a whole write frame must leave no trace
  task automatic t_freeze;
    @(negedge clk);
    ce = 1'b0;
    host.select(1'b1);
    host.word(16'h3901, 16, rx);
    host.word(16'h00C0, 16, rx);
    host.select(1'b0);
    check({14'h0000, reg_wr, mode_b}, 16'h0000);
    @(negedge clk);
    ce = 1'b1;
    wr1(10'h1C8, 16'h002A, 16'hAAA8);
    check({15'h0000, mode_b}, 16'h0000);
  endtask : t_freeze
  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // watchdog: the tests need about 50 us
  initial
  begin
    #400000;
    fails++;
    end_sim();
  end
  // main sequence: reset for four cycles, then the scenarios
  initial
  begin
    fails    = 0;
    n_checks = 0;
    rst_n    = 1'b0;
    ce       = 1'b1;
    cks_miss = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_mode_b();
    t_frame_err();
    t_word_err();
    t_burst();
    t_freeze();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
